// file: hdl/chbh_host.sv
// host-side controller for the card parallel bus handshake
`timescale 1ns/1ps
// Functional notes
// - ultra dma read: host captures a word on both strobe edges
// - memory mode: write strobe writes task and configuration registers
// - io mode: write strobe writes configuration registers only
// - disk mode: card ignores write strobe; host holds it high
// - host holds mode select stable from power up through reset; code drives it high in reset, low for disk mode only after release
module chbh_host
  import chbh_pkg::*;
#(
  parameter int DATA_W = CHBH_DATA_W
)(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // user side
  input wire logic [1:0] i_mode,
  input wire logic i_wr_req,
  input wire logic [DATA_W-1:0] i_wr_data,
  output logic o_wr_busy,
  input wire logic i_udma_wr,
  input wire logic i_udma_rd,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  input wire logic i_rd_ready,
  output logic o_wide_seen,
  output logic o_wp_seen,
  // card pins
  output logic o_mode_sel,
  output logic o_we_n,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_dmack_n,
  input wire logic i_wait_n,
  input wire logic i_ddmardy_n,
  input wire logic i_dstrobe,
  input wire logic [DATA_W-1:0] i_dq,
  input wire logic i_iois16_n,
  input wire logic i_wp
);

  typedef enum logic [1:0] {CHBH_IDLE, CHBH_STROBE, CHBH_HOLD} chbh_st_t;

  typedef struct packed {
    chbh_st_t st;
    logic [CHBH_CNT_W-1:0] cnt;
    logic we_n;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic dmack_n;
    logic mode_sel;
    logic strobe_d;
    logic [CHBH_BUF_DEPTH-1:0] bvld;
    logic [CHBH_BUF_DEPTH-1:0][DATA_W-1:0] bdat;
    logic wr_busy;
    logic wide;
    logic wp;
  } chbh_state_t;

  chbh_state_t s_r;
  chbh_state_t s_nxt;
  logic cap;
  logic pop;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.mode_sel = (i_mode != CHBH_MODE_DISK);
    s_nxt.dmack_n = !((i_udma_wr || i_udma_rd) && i_mode == CHBH_MODE_DISK);
    s_nxt.strobe_d = i_dstrobe;
    s_nxt.wide = (i_mode != CHBH_MODE_MEM) && !i_iois16_n;
    s_nxt.wp = (i_mode == CHBH_MODE_MEM) && i_wp;
    cap = !s_r.dmack_n && i_udma_rd && (i_dstrobe != s_r.strobe_d);
    pop = s_r.bvld[0] && i_rd_ready;
    if (pop)
    begin
      s_nxt.bdat[0] = s_r.bdat[1];
      s_nxt.bvld = {1'b0, s_r.bvld[1]};
    end
    if (cap)
    begin
      // a word arriving with both slots full is lost unless slot 0 pops in the same cycle; nothing pauses the card first
      if (!s_nxt.bvld[0])
      begin
        s_nxt.bdat[0] = i_dq;
        s_nxt.bvld[0] = 1'b1;
      end
      else if (!s_nxt.bvld[1])
      begin
        s_nxt.bdat[1] = i_dq;
        s_nxt.bvld[1] = 1'b1;
      end
    end
    case (s_r.st)
      CHBH_IDLE:
      begin
        s_nxt.we_n = 1'b1;
        s_nxt.wr_busy = 1'b0;
        if (i_mode == CHBH_MODE_DISK && i_udma_wr && !s_r.dmack_n && !i_ddmardy_n && i_wr_req)
        begin
          s_nxt.dq = i_wr_data;
          s_nxt.dq_oe = 1'b1;
        end
        else if (i_wr_req && i_mode != CHBH_MODE_DISK)
        begin
          s_nxt.dq = i_wr_data;
          s_nxt.dq_oe = 1'b1;
          s_nxt.we_n = 1'b0;
          s_nxt.wr_busy = 1'b1;
          s_nxt.cnt = CHBH_CNT_W'(CHBH_STROBE_CYC);
          s_nxt.st = CHBH_STROBE;
        end
        else
        begin
          s_nxt.dq_oe = 1'b0;
        end
      end
      CHBH_STROBE:
      begin
        if (s_r.cnt > CHBH_CNT_RST)
        begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
        else if (i_wait_n)
        begin
          s_nxt.we_n = 1'b1;
          s_nxt.st = CHBH_HOLD;
        end
      end
      CHBH_HOLD:
      begin
        s_nxt.dq_oe = 1'b0;
        s_nxt.wr_busy = 1'b0;
        s_nxt.st = CHBH_IDLE;
      end
      default:
      begin
        s_nxt.st = CHBH_IDLE;
      end
    endcase
    if (i_mode == CHBH_MODE_DISK && !i_udma_wr && !i_wait_n && s_r.st == CHBH_IDLE)
    begin
      s_nxt.dq_oe = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_r <= '0;
      s_r.st <= CHBH_IDLE;
      s_r.we_n <= 1'b1;
      s_r.dmack_n <= 1'b1;
      s_r.mode_sel <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_wr_busy = s_r.wr_busy;
  assign o_rd_valid = s_r.bvld[0];
  assign o_rd_data = s_r.bdat[0];
  assign o_wide_seen = s_r.wide;
  assign o_wp_seen = s_r.wp;
  assign o_mode_sel = s_r.mode_sel;
  assign o_we_n = s_r.we_n;
  assign o_dq = s_r.dq;
  assign o_dq_oe = s_r.dq_oe;
  assign o_dmack_n = s_r.dmack_n;

  property p_disk_we_high;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_mode == CHBH_MODE_DISK && s_r.st == CHBH_IDLE) |=> o_we_n;
  endproperty
  a_disk_we_high: assert property (p_disk_we_high) else $error("write strobe low in disk mode");

  sequence s_wr_start;
    s_r.st == CHBH_IDLE && i_wr_req && i_mode == CHBH_MODE_MEM;
  endsequence
  property p_mem_write;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      s_wr_start |=> !o_we_n && o_dq_oe;
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("memory write did not strobe");

  property p_io_write;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (s_r.st == CHBH_IDLE && i_wr_req && i_mode == CHBH_MODE_IO) |=> o_wr_busy;
  endproperty
  a_io_write: assert property (p_io_write) else $error("io write did not start");

  property p_stretch;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (s_r.st == CHBH_STROBE && s_r.cnt == CHBH_CNT_RST && !i_wait_n) |=> !o_we_n;
  endproperty
  a_stretch: assert property (p_stretch) else $error("strobe ended during stretch");

  property p_capture;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (cap && !s_r.bvld[0]) |=> o_rd_valid && o_rd_data == $past(i_dq);
  endproperty
  a_capture: assert property (p_capture) else $error("strobe edge not captured");

  property p_pause;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_dstrobe == s_r.strobe_d && !pop) |=> $stable(o_rd_valid);
  endproperty
  a_pause: assert property (p_pause) else $error("word taken without strobe edge");

  property p_dmack;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (!i_udma_wr && !i_udma_rd) |=> o_dmack_n;
  endproperty
  a_dmack: assert property (p_dmack) else $error("acknowledge outside dma");

  property p_mode_sel;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_mode == CHBH_MODE_DISK) [*2] |-> !o_mode_sel;
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode select wrong");

  property p_wide_idle;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      i_iois16_n |=> !o_wide_seen;
  endproperty
  a_wide_idle: assert property (p_wide_idle) else $error("wide seen while idle high");

endmodule : chbh_host

// file: hdl/chbh_pkg.sv
// constants for the card host bus handshake controller
package chbh_pkg;
  localparam logic [1:0] CHBH_MODE_MEM = 2'h0;
  localparam logic [1:0] CHBH_MODE_IO = 2'h1;
  localparam logic [1:0] CHBH_MODE_DISK = 2'h2;
  localparam int CHBH_CLK_PERIOD_NS = 10;
  localparam int CHBH_STROBE_NS = 150;
  localparam int CHBH_STROBE_CYC = (CHBH_STROBE_NS + CHBH_CLK_PERIOD_NS - 1) / CHBH_CLK_PERIOD_NS;
  localparam int CHBH_CNT_W = 8;
  localparam logic [CHBH_CNT_W-1:0] CHBH_CNT_RST = 8'h00;
  localparam int CHBH_DATA_W = 16;
  localparam int CHBH_BUF_DEPTH = 2;
endpackage : chbh_pkg

// file: bench/chbh_card.sv
// behavioural card model facing the host controller
`timescale 1ns/1ps
module chbh_card
  import chbh_pkg::*;
(
  // host pins
  input wire logic i_mode_sel,
  input wire logic i_we_n,
  input wire logic [15:0] i_dq,
  input wire logic i_dmack_n,
  // scenario controls
  input wire logic i_wide,
  input wire logic i_pause,
  input wire logic i_stall,
  // card pins
  output logic o_wait_n,
  output logic o_ddmardy_n,
  output logic o_dstrobe = 1'b0,
  output logic [15:0] o_dq = 16'h0,
  output logic o_iois16_n,
  output logic o_wp,
  output logic [15:0] o_last_wr = 16'h0
);
  // this card never stretches; a stall is only forced to prove the host waits
  assign o_wait_n = !i_stall;
  assign o_wp = 1'b0; // no switch fitted
  assign o_iois16_n = !i_wide; // idle high
  assign o_ddmardy_n = i_pause | i_dmack_n;
  // disk mode ignores the strobe entirely
  always @(posedge i_we_n)
    if (i_mode_sel)
      o_last_wr = i_dq;
  // one strobe edge per word; send toggles the strobe even while i_pause is set
  task automatic send(input logic [15:0] w);
    o_dq = w;
    o_dstrobe = ~o_dstrobe;
  endtask : send
endmodule : chbh_card

// file: bench/chbh_host_tb.sv
// testbench for the card host bus handshake controller
`timescale 1ns/1ps
module chbh_host_tb;
  import chbh_pkg::*;
  logic i_sys_clk = 0, i_nrst = 0, i_wr_req = 0, i_udma_wr = 0, i_udma_rd = 0, i_rd_ready = 0;
  logic [1:0] i_mode = CHBH_MODE_MEM;
  logic [15:0] i_wr_data = 16'h0, o_rd_data, o_dq, card_dq, last_wr;
  logic o_wr_busy, o_rd_valid, o_wide_seen, o_wp_seen, o_mode_sel, o_we_n, o_dq_oe, o_dmack_n;
  logic wait_n, ddmardy_n, dstrobe, iois16_n, wp, wide = 0, pause = 0, stall = 0;
  int num_errors = 0, n_tests = 0, cycles = 0, n;
  chbh_host chbh_host_inst (.i_sys_clk, .i_nrst, .i_mode, .i_wr_req, .i_wr_data, .o_wr_busy,
    .i_udma_wr, .i_udma_rd, .o_rd_valid, .o_rd_data, .i_rd_ready, .o_wide_seen, .o_wp_seen,
    .o_mode_sel, .o_we_n, .o_dq, .o_dq_oe, .o_dmack_n, .i_wait_n(wait_n), .i_ddmardy_n(ddmardy_n),
    .i_dstrobe(dstrobe), .i_dq(card_dq), .i_iois16_n(iois16_n), .i_wp(wp));
  // a released data bus shows the inverse, so a late latch picks up garbage
  chbh_card chbh_card_inst (.i_mode_sel(o_mode_sel), .i_we_n(o_we_n),
    .i_dq(o_dq_oe ? o_dq : ~o_dq), .i_stall(stall),
    .i_dmack_n(o_dmack_n), .i_wide(wide), .i_pause(pause), .o_wait_n(wait_n),
    .o_ddmardy_n(ddmardy_n), .o_dstrobe(dstrobe), .o_dq(card_dq), .o_iois16_n(iois16_n),
    .o_wp(wp), .o_last_wr(last_wr));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task automatic tick(input int k);
    repeat (k) @(negedge i_sys_clk);
  endtask : tick
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // mode is only changed while reset is held
  task automatic restart(input logic [1:0] m);
    i_nrst = 0;
    i_mode = m;
    tick(5);
    i_nrst = 1;
    tick(1);
  endtask : restart
  task automatic strobe_write(input logic [15:0] d, input bit strobes, input logic [15:0] exp);
    i_wr_data = d;
    i_wr_req = 1;
    n = 0;
    for (int k = 0; k < 4 && o_we_n !== 1'b0; k++) tick(1);
    check("busy", 16'(o_wr_busy), 16'(strobes));
    i_wr_req = 0;
    while (o_we_n === 1'b0 && n < 40)
    begin
      n++;
      tick(1);
    end
    check("strobe width", 16'(n >= CHBH_STROBE_CYC), 16'(strobes));
    tick(2);
    check("card word", last_wr, exp);
    check("busy done", 16'(o_wr_busy), 16'h0);
    check("oe done", 16'(o_dq_oe), 16'h0);
  endtask : strobe_write
  task automatic t_mem;
    restart(CHBH_MODE_MEM);
    check("mode sel", o_mode_sel, 1);
    strobe_write(16'ha5c3, 1, 16'ha5c3);
    check("wp seen", o_wp_seen, 0);
  endtask : t_mem
  // forced stretch: strobe must stay low until the card lets go
  task automatic t_stretch;
    stall = 1;
    i_wr_data = 16'h6699;
    i_wr_req = 1;
    tick(1);
    i_wr_req = 0;
    tick(20);
    check("we held", 16'(o_we_n), 16'h0);
    stall = 0;
    tick(2);
    check("we released", 16'(o_we_n), 16'h1);
    tick(2);
    check("stretched word", last_wr, 16'h6699);
  endtask : t_stretch
  task automatic t_io;
    restart(CHBH_MODE_IO);
    strobe_write(16'h3c5a, 1, 16'h3c5a);
    wide = 1;
    tick(3);
    check("wide seen", o_wide_seen, 1);
    wide = 0;
    tick(3);
    check("wide idle", o_wide_seen, 0);
  endtask : t_io
  task automatic t_disk;
    restart(CHBH_MODE_DISK);
    check("mode sel", o_mode_sel, 0);
    strobe_write(16'h1234, 0, 16'h3c5a);
    check("dmack idle", o_dmack_n, 1);
    wide = 1;
    tick(3);
    check("wide seen", o_wide_seen, 1);
    wide = 0;
    i_udma_rd = 1;
    tick(3);
    check("dmack on", o_dmack_n, 0);
    chbh_card_inst.send(16'h0f0f);
    tick(4);
    chbh_card_inst.send(16'hf0f0);
    tick(1);
    chbh_card_inst.send(16'h5555);
    tick(2);
    check("rd first", o_rd_data, 16'h0f0f);
    i_rd_ready = 1;
    tick(1);
    check("rd second", o_rd_data, 16'hf0f0);
    tick(1);
    check("rd empty", o_rd_valid, 0);
    i_rd_ready = 0;
    i_udma_rd = 0;
    tick(3);
    i_udma_wr = 1;
    i_wr_data = 16'hbeef;
    i_wr_req = 1;
    tick(4);
    check("udma out", o_dq_oe ? o_dq : 16'h0, 16'hbeef);
    pause = 1;
    tick(3);
    check("udma paused", o_dq_oe, 0);
    i_wr_req = 0;
    i_udma_wr = 0;
  endtask : t_disk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // whole run needs well under a thousand cycles
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    t_mem();
    t_stretch();
    t_io();
    t_disk();
    finish_test();
  end
endmodule : chbh_host_tb
